/* efc_cmd_clock.sv */
module efc_cmd_clock
   import efc_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic reset_n, // Async reset
   input wire logic [7:0] scaler, // Scaler value
   output logic tick // One-cycle command clock enable
);
   // ---------------------------------------------------------------
   // Fractional accumulator
   // ---------------------------------------------------------------
   // Adds scaler+1 per cycle; carry out of 8 bits is a tick
   logic [7:0] acc;
   logic [7:0] next_acc;
   logic next_tick;
   logic [8:0] sum;

   always_comb begin
      sum = {1'b0, acc} + {1'b0, scaler} + 9'h001;
      next_acc = sum[7:0];
      next_tick = sum[8];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc <= 8'h00;
         tick <= 1'b0;
      end else begin
         acc <= next_acc;
         tick <= next_tick;
      end
   end
endmodule : efc_cmd_clock

/* efc_controller.sv */
module efc_controller
   import efc_pkg::*;
#(
   parameter int MAIN_BYTES = 131072,
   parameter int INFO_BYTES = EFC_INFO_BYTES
) (
   input wire logic REF_CLK, // 40 MHz system clock
   input wire logic RESET_N, // Async reset, active low
   input wire logic [15:0] REG_ADDR, // Register address
   input wire logic REG_WR, // Register write strobe
   input wire logic REG_RD, // Register read strobe
   input wire logic [7:0] REG_WDATA, // Register write data
   output logic [7:0] REG_RDATA, // Register read data
   output logic CPU_STALL, // Holds processor idle
   input wire logic FUSE_SEL, // Fuse block selected as info target
   output logic ARR_INFO, // Access goes to info block
   output logic [16:0] ARR_ADDR, // Array byte address
   output logic [7:0] ARR_WDATA, // Array program data
   output logic ARR_READ, // Array read pulse
   output logic ARR_WRITE, // Array program level
   output logic ARR_ERASE, // Array sector erase level
   input wire logic [7:0] ARR_RDATA // Array read data, same clock
);
   // Elaboration-time refusal of geometries the decode cannot serve
   if (MAIN_BYTES != 131072 || INFO_BYTES != EFC_INFO_BYTES) begin : g_bad_geometry
      $error("Unsupported array geometry");
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [4:0] cmd, next_cmd;
   logic [2:0] cyc, next_cyc;
   logic write_verify_ok, next_write_verify_ok;
   logic fail, next_fail;
   logic [7:0] data, next_data;
   logic [7:0] addr_h, next_addr_h;
   logic [7:0] addr_l, next_addr_l;
   logic addr_t, next_addr_t;
   logic [7:0] scaler, next_scaler;
   logic [7:0] low_zone, next_low_zone;
   logic [7:0] high_zone, next_high_zone;
   logic [7:0] rdata, next_rdata;
   efc_state_t state, next_state;
   logic [15:0] count, next_count;
   logic stall, next_stall;
   logic a_info, next_a_info, a_rd, next_a_rd, a_wr, next_a_wr, a_er, next_a_er;
   logic tick;
   logic busy;
   logic [16:0] target;
   logic [7:0] unit;
   logic zone_hit, cmd_valid, is_mod, info_rsvd;

   efc_cmd_clock u_clk (
      .clk(REF_CLK),
      .reset_n(RESET_N),
      .scaler(scaler),
      .tick(tick)
   );

   function automatic logic onehot_cmd(input logic [4:0] c);
      return (c == EFC_CMD_MAIN_READ) || (c == EFC_CMD_MAIN_ERASE) ||
             (c == EFC_CMD_MAIN_WRITE) || (c == EFC_CMD_INFO_READ) ||
             (c == EFC_CMD_INFO_WRITE);
   endfunction : onehot_cmd

   // ---------------------------------------------------------------
   // Decode and protection
   // ---------------------------------------------------------------
   always_comb begin
      busy = (state != EFC_IDLE);
      target = {addr_t, addr_h, addr_l};
      unit = target[16:9];
      cmd_valid = onehot_cmd(cmd);
      is_mod = (cmd == EFC_CMD_MAIN_ERASE) || (cmd == EFC_CMD_MAIN_WRITE);
      // Low zone covers units below bound; high zone units above bound
      zone_hit = (unit < low_zone) || (unit > high_zone);
      info_rsvd = (addr_l >= EFC_INFO_RSVD_BASE) || FUSE_SEL;
   end

   // ---------------------------------------------------------------
   // Register access and sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_cmd = cmd;
      next_cyc = cyc;
      next_write_verify_ok = write_verify_ok;
      next_fail = fail;
      next_data = data;
      next_addr_h = addr_h;
      next_addr_l = addr_l;
      next_addr_t = addr_t;
      next_scaler = scaler;
      next_low_zone = low_zone;
      next_high_zone = high_zone;
      next_rdata = rdata;
      next_state = state;
      next_count = count;
      next_a_info = a_info;
      next_a_rd = 1'b0;
      next_a_wr = a_wr;
      next_a_er = a_er;
      if (REG_RD) begin
         unique case (REG_ADDR)
            EFC_OFS_CMD: next_rdata = {write_verify_ok, busy, fail, cmd};
            EFC_OFS_DATA: next_rdata = data;
            EFC_OFS_ADDRH: next_rdata = addr_h;
            EFC_OFS_ADDRL: next_rdata = addr_l;
            EFC_OFS_SCALER: next_rdata = scaler;
            EFC_OFS_LOWZONE: next_rdata = low_zone;
            EFC_OFS_HIGHZONE: next_rdata = high_zone;
            EFC_OFS_ADDRT: next_rdata = {7'h00, addr_t};
            default: next_rdata = 8'h00;
         endcase
      end
      // CPU is stalled while busy, so writes only land in idle
      if (REG_WR && !busy) begin
         unique case (REG_ADDR)
            EFC_OFS_CMD: begin
               next_cmd = REG_WDATA[4:0];
               next_cyc = REG_WDATA[7:EFC_CYC_LSB];
               next_fail = 1'b0;
               next_write_verify_ok = 1'b1;
               next_state = EFC_CHECK;
            end
            EFC_OFS_DATA: next_data = REG_WDATA;
            EFC_OFS_ADDRH: next_addr_h = REG_WDATA;
            EFC_OFS_ADDRL: next_addr_l = REG_WDATA;
            EFC_OFS_SCALER: next_scaler = REG_WDATA;
            EFC_OFS_LOWZONE: next_low_zone = REG_WDATA;
            EFC_OFS_HIGHZONE: next_high_zone = REG_WDATA;
            EFC_OFS_ADDRT: next_addr_t = REG_WDATA[0];
            default: ;
         endcase
      end
      unique case (state)
         EFC_IDLE: ;
         EFC_CHECK: begin
            next_a_info = (cmd == EFC_CMD_INFO_READ) || (cmd == EFC_CMD_INFO_WRITE);
            if (!cmd_valid) begin
               next_fail = 1'b1;
               next_state = EFC_DONE;
            end else if (is_mod && zone_hit) begin
               next_fail = 1'b1;
               next_state = EFC_DONE;
            end else if (cmd == EFC_CMD_INFO_WRITE && info_rsvd) begin
               next_fail = 1'b1;
               next_state = EFC_DONE;
            end else if (cmd == EFC_CMD_MAIN_READ || cmd == EFC_CMD_INFO_READ) begin
               next_a_rd = 1'b1;
               next_state = EFC_VERIFY;
            end else begin
               next_a_er = (cmd == EFC_CMD_MAIN_ERASE);
               next_a_wr = (cmd != EFC_CMD_MAIN_ERASE);
               next_count = next_a_er ? EFC_ERASE_CYCLES[cyc] : EFC_WRITE_CYCLES[cyc];
               next_state = EFC_RUN;
            end
         end
         EFC_RUN: begin
            if (tick) begin
               // Counted in command clock periods
               if (count == 16'h0001) begin
                  next_a_wr = 1'b0;
                  next_a_er = 1'b0;
                  next_a_rd = a_wr;
                  next_state = a_wr ? EFC_VERIFY : EFC_DONE;
               end
               next_count = count - 16'h0001;
            end
         end
         EFC_VERIFY: begin
            if (!a_rd) begin
               if (cmd == EFC_CMD_MAIN_WRITE || cmd == EFC_CMD_INFO_WRITE) begin
                  next_write_verify_ok = (ARR_RDATA == data);
               end else begin
                  next_data = ARR_RDATA;
               end
               next_state = EFC_DONE;
            end
         end
         EFC_DONE: next_state = EFC_IDLE;
         default: next_state = EFC_IDLE;
      endcase
      next_stall = (next_state != EFC_IDLE);
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cmd <= EFC_RST_CMD[4:0];
         cyc <= EFC_RST_CYC;
         write_verify_ok <= EFC_RST_CMD[EFC_BIT_WRITE_VERIFY_OK];
         fail <= EFC_RST_CMD[EFC_BIT_FAIL];
         data <= EFC_RST_DATA;
         addr_h <= EFC_RST_ADDR;
         addr_l <= EFC_RST_ADDR;
         addr_t <= 1'b0;
         scaler <= EFC_RST_SCALER;
         low_zone <= EFC_RST_LOWZONE;
         high_zone <= EFC_RST_HIGHZONE;
         rdata <= 8'h00;
         state <= EFC_IDLE;
         count <= 16'h0000;
         stall <= 1'b0;
         a_info <= 1'b0;
         a_rd <= 1'b0;
         a_wr <= 1'b0;
         a_er <= 1'b0;
      end else begin
         cmd <= next_cmd;
         cyc <= next_cyc;
         write_verify_ok <= next_write_verify_ok;
         fail <= next_fail;
         data <= next_data;
         addr_h <= next_addr_h;
         addr_l <= next_addr_l;
         addr_t <= next_addr_t;
         scaler <= next_scaler;
         low_zone <= next_low_zone;
         high_zone <= next_high_zone;
         rdata <= next_rdata;
         state <= next_state;
         count <= next_count;
         stall <= next_stall;
         a_info <= next_a_info;
         a_rd <= next_a_rd;
         a_wr <= next_a_wr;
         a_er <= next_a_er;
      end
   end

   // ---------------------------------------------------------------
   // Array outputs
   // ---------------------------------------------------------------
   logic [16:0] arr_addr;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         arr_addr <= 17'h00000;
      end else begin
         arr_addr <= target;
      end
   end

   always_comb begin
      REG_RDATA = rdata;
      CPU_STALL = stall;
      ARR_INFO = a_info;
      ARR_ADDR = arr_addr;
      ARR_WDATA = data;
      ARR_READ = a_rd;
      ARR_WRITE = a_wr;
      ARR_ERASE = a_er;
   end
endmodule : efc_controller

/* efc_controller_sva.sv */
module efc_controller_sva
   import efc_pkg::*;
#(
   parameter int MAIN_BYTES = 131072, // Main bytes
   parameter int INFO_BYTES = EFC_INFO_BYTES // Info bytes
) (
   input wire logic REF_CLK, // Clock
   input wire logic RESET_N, // Reset
   input wire logic [15:0] REG_ADDR, // Reg address
   input wire logic REG_WR, // Reg write
   input wire logic REG_RD, // Reg read
   input wire logic [7:0] REG_WDATA, // Reg wdata
   input wire logic [7:0] REG_RDATA, // Reg rdata
   input wire logic CPU_STALL, // Stall
   input wire logic FUSE_SEL, // Fuse target
   input wire logic ARR_INFO, // Info access
   input wire logic [16:0] ARR_ADDR, // Array address
   input wire logic [7:0] ARR_WDATA, // Array wdata
   input wire logic ARR_READ, // Array read
   input wire logic ARR_WRITE, // Array write
   input wire logic ARR_ERASE, // Array erase
   input wire logic [7:0] ARR_RDATA // Array rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] wr_len;
   logic [15:0] er_len;
   // ---------------------------------------------------------------
   // Level lengths, too long for a repetition
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wr_len <= 16'h0000;
         er_len <= 16'h0000;
      end else begin
         wr_len <= ARR_WRITE ? wr_len + 16'h0001 : 16'h0000;
         er_len <= ARR_ERASE ? er_len + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);
   AST_CMD_STALLS:
      assert property (REG_WR && REG_ADDR == EFC_OFS_CMD && !CPU_STALL
         && $onehot(REG_WDATA[4:0]) |=> CPU_STALL) else $error("no stall");
   AST_BAD_CMD_IDLE:
      assert property (REG_WR && REG_ADDR == EFC_OFS_CMD && !CPU_STALL
         && !$onehot(REG_WDATA[4:0]) |=> (!ARR_READ && !ARR_WRITE && !ARR_ERASE) [*4])
      else $error("bad command ran");
   AST_ARRAY_STALLED:
      assert property (ARR_READ || ARR_WRITE || ARR_ERASE |-> CPU_STALL)
      else $error("array busy without stall");
   AST_ONE_OP:
      assert property (ARR_WRITE |-> !ARR_ERASE && !ARR_READ) else $error("ops overlap");
   AST_WRITE_STEADY:
      assert property (ARR_WRITE && $past(ARR_WRITE) |-> $stable(ARR_ADDR) && $stable(ARR_WDATA))
      else $error("write target moved");
   AST_WRITE_LEN:
      assert property ($fell(ARR_WRITE) |-> wr_len >= EFC_WRITE_CYCLES[0]) else $error("write short");
   AST_ERASE_LEN:
      assert property ($fell(ARR_ERASE) |-> er_len >= EFC_ERASE_CYCLES[0]) else $error("erase short");
   AST_VERIFY_READ:
      assert property ($fell(ARR_WRITE) |-> ##[0:4] ARR_READ) else $error("no readback");
   AST_STALL_ENDS:
      assert property ($fell(ARR_READ) |-> ##[0:6] !CPU_STALL) else $error("stall stuck");
   AST_RDATA_HOLDS:
      assert property (!$past(REG_RD) |-> $stable(REG_RDATA)) else $error("rdata moved");
   COV_ERASE: cover property ($rose(ARR_ERASE));
   COV_WRITE: cover property ($rose(ARR_WRITE));
   COV_INFO_READ: cover property (ARR_READ && ARR_INFO);
endmodule : efc_controller_sva

bind efc_controller efc_controller_sva #(.MAIN_BYTES(MAIN_BYTES), .INFO_BYTES(INFO_BYTES))
   efc_controller_sva_inst (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .CPU_STALL(CPU_STALL), .FUSE_SEL(FUSE_SEL), .ARR_INFO(ARR_INFO), .ARR_ADDR(ARR_ADDR),
   .ARR_WDATA(ARR_WDATA), .ARR_READ(ARR_READ), .ARR_WRITE(ARR_WRITE),
   .ARR_ERASE(ARR_ERASE), .ARR_RDATA(ARR_RDATA));

/* efc_controller_tb_top.sv */
module efc_controller_tb_top
   import efc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] cmd;
      logic [16:0] addr;
      logic [7:0] dat;
      logic fuse;
      logic [7:0] st;
      logic [8:0] rdx;
   } efc_row_t;
   logic REF_CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic [15:0] REG_ADDR = 16'h0000;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [7:0] REG_WDATA = 8'h00;
   logic FUSE_SEL = 1'b0;
   logic corrupt = 1'b0;
   logic [7:0] REG_RDATA, ARR_WDATA, ARR_RDATA, rd;
   logic CPU_STALL, ARR_INFO, ARR_READ, ARR_WRITE, ARR_ERASE;
   logic [16:0] ARR_ADDR;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   int wlen = 0;
   int last_wlen = 0;
   int elen = 0;
   int last_elen = 0;
   logic [15:0] ra [9] = '{EFC_OFS_CMD, EFC_OFS_DATA, EFC_OFS_ADDRH, EFC_OFS_ADDRL,
      EFC_OFS_SCALER, EFC_OFS_LOWZONE, EFC_OFS_HIGHZONE, EFC_OFS_ADDRT, 16'hA027};
   logic [7:0] rv [9] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h25, 8'hFF, 8'h00, 8'h00, 8'h00};
   efc_row_t rows [18] = '{
      '{8'hE4, 17'h00400, 8'h5A, 1'b0, 8'h80, 9'h000}, '{8'hE4, 17'h00800, 8'h22, 1'b0, 8'h80, 9'h000},
      '{8'h10, 17'h00400, 8'h00, 1'b0, 8'h80, 9'h15A}, '{8'h08, 17'h00555, 8'h00, 1'b0, 8'h80, 9'h000},
      '{8'h10, 17'h00400, 8'h00, 1'b0, 8'h80, 9'h1FF}, '{8'h10, 17'h00800, 8'h00, 1'b0, 8'h80, 9'h122},
      '{8'hE4, 17'h001FF, 8'h00, 1'b0, 8'hA0, 9'h000}, '{8'h10, 17'h001FF, 8'h00, 1'b0, 8'h80, 9'h1FF},
      '{8'hE4, 17'h00200, 8'h33, 1'b0, 8'h80, 9'h000}, '{8'hE4, 17'h1E1FF, 8'h44, 1'b0, 8'h80, 9'h000},
      '{8'h08, 17'h1FC00, 8'h00, 1'b0, 8'hA0, 9'h000}, '{8'h03, 17'h00000, 8'h00, 1'b0, 8'hA0, 9'h000},
      '{8'h12, 17'h00000, 8'h00, 1'b0, 8'hA0, 9'h000}, '{8'hE1, 17'h00010, 8'h77, 1'b0, 8'h80, 9'h000},
      '{8'h02, 17'h00010, 8'h00, 1'b0, 8'h80, 9'h177}, '{8'hE1, 17'h000C0, 8'h66, 1'b0, 8'hA0, 9'h000},
      '{8'hE1, 17'h00020, 8'h55, 1'b1, 8'hA0, 9'h000}, '{8'h02, 17'h00020, 8'h00, 1'b1, 8'h80, 9'h1FF}};
   efc_controller efc_controller_inst (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
      .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .CPU_STALL(CPU_STALL), .FUSE_SEL(FUSE_SEL), .ARR_INFO(ARR_INFO),
      .ARR_ADDR(ARR_ADDR), .ARR_WDATA(ARR_WDATA), .ARR_READ(ARR_READ), .ARR_WRITE(ARR_WRITE),
      .ARR_ERASE(ARR_ERASE), .ARR_RDATA(ARR_RDATA));
   efc_flash_model efc_flash_model_inst (.clk(REF_CLK), .corrupt(corrupt), .arr_info(ARR_INFO),
      .arr_addr(ARR_ADDR), .arr_wdata(ARR_WDATA), .arr_read(ARR_READ), .arr_write(ARR_WRITE),
      .arr_erase(ARR_ERASE), .arr_rdata(ARR_RDATA));
   always #12.5 REF_CLK = ~REF_CLK;
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   // Erases dominate the run; the ceiling leaves ample margin
   always @(posedge REF_CLK) begin
      cycles++;
      wlen <= ARR_WRITE ? wlen + 1 : 0;
      if (!ARR_WRITE && wlen != 0)
         last_wlen <= wlen;
      elen <= ARR_ERASE ? elen + 1 : 0;
      if (!ARR_ERASE && elen != 0)
         last_elen <= elen;
      if (cycles == 60000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic check(input string nm, input logic [16:0] got, input logic [16:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge REF_CLK) #1;
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      @(posedge REF_CLK) #1;
      REG_WR = 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge REF_CLK) #1;
      REG_ADDR = a;
      REG_RD = 1'b1;
      @(posedge REF_CLK) #1;
      REG_RD = 1'b0;
      d = REG_RDATA;
   endtask : reg_rd
   task automatic set_regs(input logic [16:0] a, input logic [7:0] d);
      reg_wr(EFC_OFS_ADDRT, {7'h00, a[16]});
      reg_wr(EFC_OFS_ADDRH, a[15:8]);
      reg_wr(EFC_OFS_ADDRL, a[7:0]);
      reg_wr(EFC_OFS_DATA, d);
   endtask : set_regs
   task automatic run_cmd(input logic [7:0] c, input logic [16:0] a, input logic [7:0] d);
      set_regs(a, d);
      reg_wr(EFC_OFS_CMD, c);
      while (CPU_STALL === 1'b1) @(posedge REF_CLK) #1;
   endtask : run_cmd
   initial begin
      repeat (8) @(posedge REF_CLK);
      #1 RESET_N = 1'b1;
      reg_wr(EFC_OFS_SCALER, 8'hFF);
      reg_wr(EFC_OFS_LOWZONE, 8'h01);
      reg_wr(EFC_OFS_HIGHZONE, 8'hF0);
      foreach (rows[i]) begin
         FUSE_SEL = rows[i].fuse;
         run_cmd(rows[i].cmd, rows[i].addr, rows[i].dat);
         reg_rd(EFC_OFS_CMD, rd);
         check("status", {9'h000, rd & 8'hE0}, {9'h000, rows[i].st});
         reg_rd(EFC_OFS_CMD, rd);
         check("status kept", {9'h000, rd & 8'hE0}, {9'h000, rows[i].st});
         if (rows[i].rdx[8] === 1'b1) begin
            reg_rd(EFC_OFS_DATA, rd);
            check("data", {9'h000, rd}, {9'h000, rows[i].rdx[7:0]});
         end
         $display("row %0d done", i);
      end
      FUSE_SEL = 1'b0;
      corrupt = 1'b1;
      run_cmd(8'hE4, 17'h00900, 8'h00);
      corrupt = 1'b0;
      reg_rd(EFC_OFS_CMD, rd);
      check("verify miss", {9'h000, rd & 8'hC0}, 17'h00000);
      run_cmd(8'h10, 17'h00900, 8'h00);
      reg_rd(EFC_OFS_CMD, rd);
      check("verify restored", {16'h0000, rd[7]}, 17'h00001);
      $display("verify test done");
      for (int k = 0; k < 8; k++) begin
         run_cmd({k[2:0], 5'h04}, 17'h00A00 + 17'(k), 8'h0F);
         check("write len", 17'(last_wlen), {1'b0, EFC_WRITE_CYCLES[k]});
      end
      reg_wr(EFC_OFS_SCALER, 8'h7F);
      run_cmd(8'h04, 17'h00B00, 8'h0F);
      check("half rate", {16'h0000, last_wlen >= 109 && last_wlen <= 111}, 17'h00001);
      $display("timing test done");
      set_regs(17'h00C00, 8'h00);
      reg_wr(EFC_OFS_CMD, 8'h08);
      reg_wr(EFC_OFS_ADDRL, 8'h77);
      reg_rd(EFC_OFS_CMD, rd);
      check("busy", {16'h0000, rd[6]}, 17'h00001);
      while (CPU_STALL === 1'b1) @(posedge REF_CLK) #1;
      reg_rd(EFC_OFS_ADDRL, rd);
      check("busy write dropped", {9'h000, rd}, 17'h00000);
      check("erase len", {16'h0000, last_elen >= 10869 && last_elen <= 10871}, 17'h00001);
      $display("busy test done");
      RESET_N = 1'b0;
      repeat (2) @(posedge REF_CLK) #1;
      RESET_N = 1'b1;
      foreach (ra[i]) begin
         reg_rd(ra[i], rd);
         check("reset value", {9'h000, rd}, {9'h000, rv[i]});
      end
      reg_wr(EFC_OFS_ADDRT, 8'hFF);
      reg_rd(EFC_OFS_ADDRT, rd);
      check("top address", {9'h000, rd}, 17'h00001);
      $display("reset test done");
      print_verdict();
   end
endmodule : efc_controller_tb_top

/* efc_flash_model.sv */
module efc_flash_model (
   input wire logic clk, // Clock
   input wire logic corrupt, // Drop programming
   input wire logic arr_info, // Info target
   input wire logic [16:0] arr_addr, // Address
   input wire logic [7:0] arr_wdata, // Program data
   input wire logic arr_read, // Read pulse
   input wire logic arr_write, // Program level
   input wire logic arr_erase, // Erase level
   output logic [7:0] arr_rdata // Read data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] main_mem [logic [16:0]];
   logic [7:0] info_mem [logic [7:0]];
   logic rd_d = 1'b0;
   logic was_wr = 1'b0;
   logic was_er = 1'b0;
   logic [7:0] junk = 8'h5A;
   function automatic logic [7:0] peek(input logic info, input logic [16:0] a);
      if (info)
         return info_mem.exists(a[7:0]) ? info_mem[a[7:0]] : 8'hFF;
      return main_mem.exists(a) ? main_mem[a] : 8'hFF;
   endfunction : peek
   // Outside the read window the bus carries a moving pattern
   assign arr_rdata = (arr_read || rd_d) ? peek(arr_info, arr_addr) : junk;
   always @(posedge clk) begin
      rd_d <= arr_read;
      junk <= junk + 8'h3B;
      was_wr <= arr_write;
      was_er <= arr_erase;
      if (was_wr && !arr_write && !corrupt) begin
         if (arr_info)
            info_mem[arr_addr[7:0]] = peek(1'b1, arr_addr) & arr_wdata;
         else
            main_mem[arr_addr] = peek(1'b0, arr_addr) & arr_wdata;
      end
      if (was_er && !arr_erase)
         for (int i = 0; i < 1024; i++) main_mem.delete({arr_addr[16:10], 10'(i)});
   end
endmodule : efc_flash_model

/* efc_pkg.sv */
package efc_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [15:0] EFC_OFS_CMD = 16'hA020;
   localparam logic [15:0] EFC_OFS_DATA = 16'hA021;
   localparam logic [15:0] EFC_OFS_ADDRH = 16'hA022;
   localparam logic [15:0] EFC_OFS_ADDRL = 16'hA023;
   localparam logic [15:0] EFC_OFS_SCALER = 16'hA024;
   localparam logic [15:0] EFC_OFS_LOWZONE = 16'hA025;
   localparam logic [15:0] EFC_OFS_HIGHZONE = 16'hA026;
   localparam logic [15:0] EFC_OFS_ADDRT = 16'hA012;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] EFC_RST_CMD = 8'h80;
   localparam logic [7:0] EFC_RST_DATA = 8'h00;
   localparam logic [7:0] EFC_RST_ADDR = 8'h00;
   localparam logic [7:0] EFC_RST_SCALER = 8'h25;
   localparam logic [7:0] EFC_RST_LOWZONE = 8'hFF;
   localparam logic [7:0] EFC_RST_HIGHZONE = 8'h00;
   localparam logic [2:0] EFC_RST_CYC = 3'h7;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int EFC_BIT_WRITE_VERIFY_OK = 7;
   localparam int EFC_BIT_BUSY = 6;
   localparam int EFC_BIT_FAIL = 5;
   localparam int EFC_CYC_LSB = 5;
   localparam logic [4:0] EFC_CMD_MAIN_READ = 5'h10;
   localparam logic [4:0] EFC_CMD_MAIN_ERASE = 5'h08;
   localparam logic [4:0] EFC_CMD_MAIN_WRITE = 5'h04;
   localparam logic [4:0] EFC_CMD_INFO_READ = 5'h02;
   localparam logic [4:0] EFC_CMD_INFO_WRITE = 5'h01;
   // ---------------------------------------------------------------
   // Array geometry and timing
   // ---------------------------------------------------------------
   localparam int EFC_SECTOR_BYTES = 1024;
   localparam int EFC_INFO_BYTES = 256;
   localparam int EFC_ZONE_BYTES = 512;
   localparam int EFC_SCALE_DEN = 256;
   localparam int EFC_SYS_CLK_HZ = 40000000;
   localparam int EFC_CMD_CLK_HZ = 2000000;
   localparam logic [7:0] EFC_INFO_RSVD_BASE = 8'hC0;
   localparam logic [15:0] EFC_WRITE_CYCLES [8] = '{16'h0037, 16'h003C, 16'h0041, 16'h0045,
                                                    16'h004B, 16'h0050, 16'h0055, 16'h0059};
   localparam logic [15:0] EFC_ERASE_CYCLES [8] = '{16'h153B, 16'h1741, 16'h1934,
                                                    16'h1AF1, 16'h1CF0, 16'h1EE2,
                                                    16'h20D4, 16'h22B9};
   typedef enum logic [2:0] {
      EFC_IDLE, EFC_CHECK, EFC_RUN, EFC_VERIFY, EFC_DONE
   } efc_state_t;
endpackage : efc_pkg
